// [logic/dxp_port.sv]
/*
 * Word exchange port between a main control computer and a spectrum
 * computer: two 16-bit word paths, ready/acknowledge flags, spare status
 * bits, reset indications in both directions and spectrum power to the main side.
 * Assumes both computers' bus lines arrive asynchronously on pins and are
 * already decoded into strobes, pulse lines and codes.
 */
`timescale 1ns/100ps
module dxp_port (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // main computer side
   input wire logic [5:0] main_dev_addr,
   input wire logic [15:0] outbound_word_lines,
   input wire logic [5:0] pulse_output_line,
   input wire logic main_console_reset,
   output logic [15:0] inbound_word_lines,
   output logic [7:0] sense_input_line,
   // spectrum computer side
   input wire logic [5:0] spec_dev_code,
   input wire logic [2:0] spec_instr,
   input wire logic [1:0] spec_ctl,
   input wire logic spec_strobe,
   input wire logic [15:0] spec_word_out,
   input wire logic spectrum_io_reset,
   input wire logic spectrum_console_reset,
   input wire logic spectrum_power_on,
   input wire logic spec_mask_in,
   output logic [15:0] spec_word_in,
   output logic spec_int_req
);
   localparam int MAIN_SW = 6 + dxp_pkg::WORD_W + dxp_pkg::PL_N + 1;
   localparam int SPEC_SW = 6 + 3 + 2 + 1 + dxp_pkg::WORD_W + 4;

   // synchronised pins
   logic [MAIN_SW-1:0] main_sync;
   logic [SPEC_SW-1:0] spec_sync;
   logic [5:0] m_addr;
   logic [15:0] m_word;
   logic [dxp_pkg::PL_N-1:0] m_pulse;
   logic m_console;
   logic [5:0] s_dev;
   logic [2:0] s_instr;
   logic [1:0] s_ctl;
   logic s_strobe;
   logic [15:0] s_word;
   logic s_io_reset;
   logic s_console;
   logic s_power;
   logic s_mask;

   dxp_sync #(
      .W(MAIN_SW)
   ) u_main_sync (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .pin_in({main_dev_addr, outbound_word_lines, pulse_output_line, main_console_reset}),
      .sync_out(main_sync)
   );

   dxp_sync #(
      .W(SPEC_SW)
   ) u_spec_sync (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .pin_in({spec_dev_code, spec_instr, spec_ctl, spec_strobe, spec_word_out,
               spectrum_io_reset, spectrum_console_reset, spectrum_power_on,
               spec_mask_in}),
      .sync_out(spec_sync)
   );

   assign {m_addr, m_word, m_pulse, m_console} = main_sync;
   assign {s_dev, s_instr, s_ctl, s_strobe, s_word, s_io_reset, s_console, s_power,
           s_mask} = spec_sync;

   // flag bank
   dxp_flag_if #(
      .N(dxp_pkg::FL_N)
   ) fl ();

   dxp_flag_bank u_flags (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .flags(fl.bank)
   );

   // state
   typedef struct packed {
      logic [dxp_pkg::PL_N-1:0] pulse_prev;
      logic m_console_prev;
      logic s_strobe_prev;
      logic s_io_reset_prev;
      logic s_console_prev;
      logic s_power_prev;
      logic [15:0] out_word;
      logic [15:0] in_word;
      logic [15:0] spec_rd;
   } dxp_port_st_t;

   dxp_port_st_t st_reg;
   dxp_port_st_t st_next;

   // decoded one-cycle events
   logic main_sel;
   logic [dxp_pkg::PL_N-1:0] pulse_ev;
   logic ev_in_ack;
   logic ev_out_data;
   logic ev_out_cmd;
   logic ev_clr_status;
   logic ev_mconsole;
   logic spec_go;
   logic ev_data_in;
   logic ev_data_out;
   logic ev_cmd_in;
   logic ev_cmd_out;
   logic ev_status_in;
   logic ev_ctl_clear;
   logic ev_ctl_pulse;
   logic ev_io_reset;
   logic ev_sconsole;
   logic ev_power_up;
   logic [15:0] status_word;

   // main side: only pulses at device address 67 reach the port; console reset is not address-decoded
   assign main_sel = (m_addr == dxp_pkg::MAIN_DEV_ADDR);
   assign pulse_ev = m_pulse & ~st_reg.pulse_prev & {dxp_pkg::PL_N{main_sel}};
   assign ev_in_ack = pulse_ev[dxp_pkg::PL_IN_ACK];
   assign ev_out_data = pulse_ev[dxp_pkg::PL_OUT_DATA];
   assign ev_out_cmd = pulse_ev[dxp_pkg::PL_OUT_CMD];
   assign ev_clr_status = pulse_ev[dxp_pkg::PL_CLR_STATUS];
   assign ev_mconsole = m_console & ~st_reg.m_console_prev;

   // spectrum side: polled device at code 04, no data channel
   assign spec_go = s_strobe & ~st_reg.s_strobe_prev
                    & (s_dev == dxp_pkg::SPEC_DEV_CODE);
   assign ev_data_in = spec_go & (s_instr == dxp_pkg::INS_DATA_IN);
   assign ev_data_out = spec_go & (s_instr == dxp_pkg::INS_DATA_OUT);
   assign ev_cmd_in = spec_go & (s_instr == dxp_pkg::INS_CMD_IN);
   assign ev_cmd_out = spec_go & (s_instr == dxp_pkg::INS_CMD_OUT);
   assign ev_status_in = spec_go & (s_instr == dxp_pkg::INS_STATUS_IN);
   // control function rides on any instruction, including the no-op one
   assign ev_ctl_clear = spec_go & (s_ctl == dxp_pkg::CTL_CLEAR);
   assign ev_ctl_pulse = spec_go & (s_ctl == dxp_pkg::CTL_PULSE);
   assign ev_io_reset = s_io_reset & ~st_reg.s_io_reset_prev;
   assign ev_sconsole = s_console & ~st_reg.s_console_prev;
   // power edge after reset release also covers power already up at reset
   assign ev_power_up = s_power & ~st_reg.s_power_prev;

   // status word for the spectrum status read
   always_comb begin
      status_word = dxp_pkg::WORD_RESET;
      status_word[dxp_pkg::STW_MRESET] = fl.q[dxp_pkg::FL_MRESET];
      status_word[dxp_pkg::STW_DATA_RDY] = fl.q[dxp_pkg::FL_S_DATA];
      status_word[dxp_pkg::STW_CMD_RDY] = fl.q[dxp_pkg::FL_S_CMD];
      status_word[dxp_pkg::STW_SPARE_ONE] = fl.q[dxp_pkg::FL_SPARE_ONE];
      status_word[dxp_pkg::STW_SPARE_TWO] = fl.q[dxp_pkg::FL_SPARE_TWO];
   end

   // flag set and clear events
   always_comb begin
      fl.set_ev = '0;
      fl.clr_ev = '0;
      // main-side sense flags
      fl.set_ev[dxp_pkg::FL_ACCEPTED] = ev_data_in | ev_cmd_in;
      fl.clr_ev[dxp_pkg::FL_ACCEPTED] = ev_out_data | ev_out_cmd;
      fl.set_ev[dxp_pkg::FL_M_DATA] = ev_data_out;
      fl.clr_ev[dxp_pkg::FL_M_DATA] = ev_in_ack | ev_io_reset | ev_ctl_clear;
      fl.set_ev[dxp_pkg::FL_M_CMD] = ev_cmd_out;
      fl.clr_ev[dxp_pkg::FL_M_CMD] = ev_in_ack | ev_io_reset | ev_ctl_clear;
      fl.set_ev[dxp_pkg::FL_STATUS_THREE] = ev_ctl_pulse;
      fl.clr_ev[dxp_pkg::FL_STATUS_THREE] = ev_clr_status | ev_io_reset
                                            | ev_ctl_clear;
      fl.set_ev[dxp_pkg::FL_SRESET] = ev_power_up | ev_io_reset | ev_sconsole;
      fl.clr_ev[dxp_pkg::FL_SRESET] = ev_clr_status;
      // spectrum-side status flags
      fl.set_ev[dxp_pkg::FL_MRESET] = ev_mconsole;
      fl.clr_ev[dxp_pkg::FL_MRESET] = ev_status_in | ev_io_reset | ev_ctl_clear;
      fl.set_ev[dxp_pkg::FL_S_DATA] = ev_out_data;
      fl.clr_ev[dxp_pkg::FL_S_DATA] = ev_data_in | ev_clr_status | ev_ctl_clear
                                      | ev_io_reset;
      fl.set_ev[dxp_pkg::FL_S_CMD] = ev_out_cmd;
      fl.clr_ev[dxp_pkg::FL_S_CMD] = ev_cmd_in | ev_clr_status | ev_ctl_clear
                                     | ev_io_reset;
      fl.set_ev[dxp_pkg::FL_SPARE_ONE] = pulse_ev[dxp_pkg::PL_SPARE_ONE];
      fl.clr_ev[dxp_pkg::FL_SPARE_ONE] = ev_clr_status | ev_ctl_clear
                                         | ev_io_reset;
      fl.set_ev[dxp_pkg::FL_SPARE_TWO] = pulse_ev[dxp_pkg::PL_SPARE_TWO];
      fl.clr_ev[dxp_pkg::FL_SPARE_TWO] = ev_clr_status | ev_ctl_clear
                                         | ev_io_reset;
   end

   // word paths and edge history
   always_comb begin
      st_next = st_reg;
      st_next.pulse_prev = m_pulse;
      st_next.m_console_prev = m_console;
      st_next.s_strobe_prev = s_strobe;
      st_next.s_io_reset_prev = s_io_reset;
      st_next.s_console_prev = s_console;
      st_next.s_power_prev = s_power;
      // outbound word is already on the lines when the ready pulse comes
      if (ev_out_data | ev_out_cmd) begin
         st_next.out_word = m_word;
      end
      // one shared inbound path for data and command words
      if (ev_data_out | ev_cmd_out) begin
         st_next.in_word = s_word;
      end
      // third output register absent: its output code falls through
      case (s_instr)
         dxp_pkg::INS_DATA_IN: begin
            if (spec_go) begin
               st_next.spec_rd = st_reg.out_word;
            end
         end
         dxp_pkg::INS_CMD_IN: begin
            if (spec_go) begin
               st_next.spec_rd = st_reg.out_word;
            end
         end
         dxp_pkg::INS_STATUS_IN: begin
            if (spec_go) begin
               st_next.spec_rd = status_word;
            end
         end
         dxp_pkg::INS_THIRD_OUT: begin
            st_next.spec_rd = st_reg.spec_rd;
         end
         default: begin
            st_next.spec_rd = st_reg.spec_rd;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // outputs
   assign inbound_word_lines = st_reg.in_word;
   assign spec_word_in = st_reg.spec_rd;

   always_comb begin
      sense_input_line = '0;
      sense_input_line[dxp_pkg::SL_ACCEPTED] = fl.q[dxp_pkg::FL_ACCEPTED];
      sense_input_line[dxp_pkg::SL_IN_DATA] = fl.q[dxp_pkg::FL_M_DATA];
      sense_input_line[dxp_pkg::SL_IN_CMD] = fl.q[dxp_pkg::FL_M_CMD];
      sense_input_line[dxp_pkg::SL_STATUS_THREE] = fl.q[dxp_pkg::FL_STATUS_THREE];
      sense_input_line[dxp_pkg::SL_SPEC_RESET] = fl.q[dxp_pkg::FL_SRESET];
      // a level, not a latch: follows the power pin through the synchroniser
      sense_input_line[dxp_pkg::SL_SPEC_POWER] = s_power;
   end

   // optional interrupt on the spectrum side, held off by its mask bit
   assign spec_int_req = (fl.q[dxp_pkg::FL_S_DATA] | fl.q[dxp_pkg::FL_S_CMD])
                         & ~s_mask;
endmodule

// [logic/dxp_pkg.sv]
/*
 * Shared constants for the dual-computer word exchange port: device codes,
 * pulse and sense line numbers, instruction and control codes, status word
 * layout and flag indices.
 * Assumes both computers present already-decoded bus lines to the port.
 */
// Functional notes
// - Two independent 16-bit word paths, one per direction, usable at once.
// - Data and command words share lines; each word uses ready then acknowledge.
// - Clear-status clears spares 1-2, spectrum-reset and both outbound ready flags.
// - Output-accepted sets on spectrum accept, clears on next outbound ready pulse.
// - Main inbound data-ready sets on spectrum data output, clears on ack/reset/clear.
// - Main inbound command-ready sets on spectrum command output, clears likewise.
// - Spare status three sets on spectrum pulse, clears on clear-status/reset/clear.
// - Spectrum-reset flag sets on power-up, I/O reset, console reset; clear-status clears.
// - Spectrum-power flag is true whenever the spectrum computer has power.
// - Main-reset flag sets on main console reset; clears on status read/reset/clear.
// - Spectrum data output raises data-ready, command output raises command-ready.
// - Third spectrum output register is absent; its output instruction does nothing.
// - Spectrum data/command input reads the word and clears its ready flag.
// - Spectrum status read returns main-reset, data, command, spares in bits 11-15.
// - Spectrum data-ready sets on outbound data pulse; clears on input/clear/reset.
// - Spectrum command-ready sets on outbound command pulse; clears on input/clear/reset.
// - Spares one and two set on main pulses; clear on clear-status/clear/reset.
// - Status three sets on control pulse code; clears on clear-status, I/O reset or clear code.
// - Spectrum side decodes device code 04, mask bit 4, polled, no data channel.
// - Main side responds to device address 67 for its pulse operations; console reset ignores the address.
package dxp_pkg;
   localparam int WORD_W = 16;
   localparam logic [5:0] MAIN_DEV_ADDR = 6'h37;
   localparam logic [5:0] SPEC_DEV_CODE = 6'h04;
   localparam logic [15:0] WORD_RESET = 16'h0000;
   // main pulse lines
   localparam int PL_IN_ACK = 0;
   localparam int PL_OUT_DATA = 1;
   localparam int PL_OUT_CMD = 2;
   localparam int PL_SPARE_ONE = 3;
   localparam int PL_SPARE_TWO = 4;
   localparam int PL_CLR_STATUS = 5;
   localparam int PL_N = 6;
   // main sense lines
   localparam int SL_ACCEPTED = 0;
   localparam int SL_IN_DATA = 1;
   localparam int SL_IN_CMD = 2;
   localparam int SL_STATUS_THREE = 3;
   localparam int SL_SPEC_RESET = 6;
   localparam int SL_SPEC_POWER = 7;
   localparam int SL_N = 8;
   // spectrum instruction and control codes
   localparam logic [2:0] INS_NOP = 3'h0;
   localparam logic [2:0] INS_DATA_IN = 3'h1;
   localparam logic [2:0] INS_DATA_OUT = 3'h2;
   localparam logic [2:0] INS_CMD_IN = 3'h3;
   localparam logic [2:0] INS_CMD_OUT = 3'h4;
   localparam logic [2:0] INS_STATUS_IN = 3'h5;
   localparam logic [2:0] INS_THIRD_OUT = 3'h6;
   localparam logic [1:0] CTL_START = 2'h1;
   localparam logic [1:0] CTL_CLEAR = 2'h2;
   localparam logic [1:0] CTL_PULSE = 2'h3;
   localparam int SPEC_MASK_BIT = 4;
   // status word bit positions
   localparam int STW_MRESET = 11;
   localparam int STW_DATA_RDY = 12;
   localparam int STW_CMD_RDY = 13;
   localparam int STW_SPARE_ONE = 14;
   localparam int STW_SPARE_TWO = 15;
   // flag bank indices
   localparam int FL_ACCEPTED = 0;
   localparam int FL_M_DATA = 1;
   localparam int FL_M_CMD = 2;
   localparam int FL_STATUS_THREE = 3;
   localparam int FL_SRESET = 4;
   localparam int FL_MRESET = 5;
   localparam int FL_S_DATA = 6;
   localparam int FL_S_CMD = 7;
   localparam int FL_SPARE_ONE = 8;
   localparam int FL_SPARE_TWO = 9;
   localparam int FL_N = 10;
endpackage

// [logic/dxp_flag_if.sv]
/*
 * Carrier between the port core and its flag bank: per-flag set and clear
 * events one way, flag levels back.
 * Assumes both ends run on core_clk.
 */
`timescale 1ns/100ps
interface dxp_flag_if #(
   parameter int N = dxp_pkg::FL_N
);
   logic [N-1:0] set_ev;
   logic [N-1:0] clr_ev;
   logic [N-1:0] q;
   modport bank (input set_ev, input clr_ev, output q);
   modport ctl (output set_ev, output clr_ev, input q);
endinterface

// [logic/dxp_sync.sv]
/*
 * Two-flop synchroniser for a bundle of pin inputs.
 * Assumes each bit is stable long enough to be caught; no bundle coherence.
 */
`timescale 1ns/100ps
module dxp_sync #(
   parameter int W = 8
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // pins in, synchronised out
   input wire logic [W-1:0] pin_in,
   output logic [W-1:0] sync_out
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stable;
   } dxp_sync_st_t;

   dxp_sync_st_t st_reg;
   dxp_sync_st_t st_next;

   always_comb begin
      st_next.meta = pin_in;
      st_next.stable = st_reg.meta;
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign sync_out = st_reg.stable;
endmodule

// [logic/dxp_flag_bank.sv]
/*
 * Bank of status flip-flops with independent set and clear events.
 * Assumes events are one-cycle pulses from the port core.
 */
`timescale 1ns/100ps
module dxp_flag_bank (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // flag events and levels
   dxp_flag_if.bank flags
);
   typedef struct packed {
      logic [dxp_pkg::FL_N-1:0] q;
   } dxp_flag_st_t;

   dxp_flag_st_t st_reg;
   dxp_flag_st_t st_next;

   always_comb begin
      // clear applied last so a coincident set always leaves it low
      st_next.q = (st_reg.q | flags.set_ev) & ~flags.clr_ev;
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign flags.q = st_reg.q;
endmodule

// [sim/dxp_port_asserts.sv]
/*
 * Checker for the word exchange port: flag and word timing seen at the pins.
 * Assumes pins change off the rising edge and strobes stay high several cycles.
 */
`timescale 1ns/100ps
module dxp_port_asserts (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // main computer side
   input wire logic [5:0] main_dev_addr,
   input wire logic [15:0] outbound_word_lines,
   input wire logic [5:0] pulse_output_line,
   input wire logic main_console_reset,
   input wire logic [15:0] inbound_word_lines,
   input wire logic [7:0] sense_input_line,
   // spectrum computer side
   input wire logic [5:0] spec_dev_code,
   input wire logic [2:0] spec_instr,
   input wire logic [1:0] spec_ctl,
   input wire logic spec_strobe,
   input wire logic [15:0] spec_word_out,
   input wire logic spectrum_io_reset,
   input wire logic spectrum_console_reset,
   input wire logic spectrum_power_on,
   input wire logic spec_mask_in,
   input wire logic [15:0] spec_word_in,
   input wire logic spec_int_req
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // a clear arriving in the same window would mask the set
   wire logic m_hit = main_dev_addr == 6'h37 && !pulse_output_line[5] && !spectrum_io_reset;
   wire logic s_hit = spec_dev_code == 6'h04 && !spectrum_io_reset;
   chk_output_accepted_flag_clear: assert property ($rose(pulse_output_line[1]) && m_hit
      |-> ##[2:4] !sense_input_line[0]) else $error("accepted flag not cleared");
   chk_data_int: assert property ($rose(pulse_output_line[1]) && m_hit
      && !spec_mask_in |-> ##[2:4] spec_int_req) else $error("data ready not raised");
   chk_read_accept: assert property ($rose(spec_strobe) && s_hit && spec_ctl == 2'h0
      && spec_instr inside {3'h1, 3'h3} |-> ##[2:4] sense_input_line[0])
      else $error("accepted flag not set");
   chk_write_word: assert property ($rose(spec_strobe) && s_hit && spec_ctl == 2'h0
      && spec_instr == 3'h2 |-> ##[2:4] sense_input_line[1]
      && inbound_word_lines == spec_word_out) else $error("inbound word not presented");
   chk_ack_clear: assert property ($rose(pulse_output_line[0])
      && main_dev_addr == 6'h37 |-> ##[2:4] sense_input_line[2:1] == 2'b00)
      else $error("inbound ready not cleared");
   chk_clear_status_pulse: assert property ($rose(pulse_output_line[5])
      && main_dev_addr == 6'h37 |-> ##[2:4] !sense_input_line[6] && !sense_input_line[3])
      else $error("clear status ignored");
   chk_io_reset: assert property ($rose(spectrum_io_reset) |-> ##[2:4]
      sense_input_line[6] && sense_input_line[3:1] == 3'b000 && !spec_int_req)
      else $error("i/o reset effect missing");
   chk_ctl_pulse: assert property ($rose(spec_strobe) && s_hit && spec_ctl == 2'h3
      |-> ##[2:4] sense_input_line[3]) else $error("status three not set");
   chk_power_sense: assert property (spectrum_power_on [*4] |-> sense_input_line[7])
      else $error("power sense missing");
   chk_mask_int: assert property (spec_mask_in [*4] |-> !spec_int_req)
      else $error("masked request raised");
endmodule

bind dxp_port dxp_port_asserts dxp_port_asserts_i (
   .core_clk, .rst_n, .main_dev_addr, .outbound_word_lines, .pulse_output_line,
   .main_console_reset, .inbound_word_lines, .sense_input_line, .spec_dev_code,
   .spec_instr, .spec_ctl, .spec_strobe, .spec_word_out, .spectrum_io_reset,
   .spectrum_console_reset, .spectrum_power_on, .spec_mask_in, .spec_word_in,
   .spec_int_req
);

// [sim/dxp_partner.sv]
/*
 * Model of both computers' bus lines facing the port.
 * Assumes tasks are called at a falling edge of core_clk.
 */
`timescale 1ns/100ps
module dxp_partner (
   // clock
   input wire logic core_clk,
   // main computer bus
   output logic [5:0] main_dev_addr,
   output logic [15:0] outbound_word_lines,
   output logic [5:0] pulse_output_line,
   output logic main_console_reset,
   // spectrum computer bus
   output logic [5:0] spec_dev_code,
   output logic [2:0] spec_instr,
   output logic [1:0] spec_ctl,
   output logic spec_strobe,
   output logic [15:0] spec_word_out,
   output logic spectrum_io_reset,
   output logic spectrum_console_reset,
   output logic spectrum_power_on,
   output logic spec_mask_in
);
   initial begin
      {main_dev_addr, outbound_word_lines, pulse_output_line, main_console_reset} = '0;
      {spec_dev_code, spec_instr, spec_ctl, spec_strobe, spec_word_out} = '0;
      {spectrum_io_reset, spectrum_console_reset, spec_mask_in} = '0;
      spectrum_power_on = 1'b1;
   end
   task automatic hold(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   task automatic main_pulse(input logic [5:0] p, input logic [5:0] a, input logic [15:0] w);
      hold(1);
      main_dev_addr = a;
      outbound_word_lines = w;
      hold(1);
      pulse_output_line = p;
      hold(4);
      pulse_output_line = 6'h00;
      hold(4);
      // released lines show the inverse so a stale word cannot pass
      outbound_word_lines = ~w;
      main_dev_addr = ~a;
   endtask
   task automatic spec_cycle(input logic [2:0] i, input logic [1:0] c, input logic [5:0] d,
         input logic [15:0] w);
      hold(1);
      {spec_instr, spec_ctl, spec_dev_code, spec_word_out} = {i, c, d, w};
      hold(1);
      spec_strobe = 1'b1;
      hold(4);
      spec_strobe = 1'b0;
      hold(4);
      {spec_instr, spec_ctl, spec_dev_code, spec_word_out} = ~{i, c, d, w};
   endtask
   task automatic reset_pins(input logic [2:0] k);
      hold(1);
      {main_console_reset, spectrum_console_reset, spectrum_io_reset} = k;
      hold(4);
      {main_console_reset, spectrum_console_reset, spectrum_io_reset} = 3'b000;
      hold(4);
   endtask
   task automatic set_level(input logic pwr, input logic msk);
      hold(1);
      spectrum_power_on = pwr;
      spec_mask_in = msk;
      hold(6);
   endtask
endmodule

// [sim/testbench.sv]
/*
 * Self-checking bench for the word exchange port.
 * Assumes the partner model drives every input except clock and reset.
 */
`timescale 1ns/100ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin bad_count++; \
   $display("wrong value %s expected %h seen %h", n, e, g); end end
module testbench;
   localparam logic [2:0] no_op = 3'h0;
   localparam logic [2:0] rd_data = 3'h1;
   localparam logic [2:0] wr_data = 3'h2;
   localparam logic [2:0] rd_cmd = 3'h3;
   localparam logic [2:0] wr_cmd = 3'h4;
   localparam logic [2:0] rd_stat = 3'h5;
   localparam logic [2:0] wr_third = 3'h6;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [5:0] main_dev_addr, pulse_output_line, spec_dev_code;
   logic [15:0] outbound_word_lines, spec_word_out, inbound_word_lines, spec_word_in;
   logic main_console_reset, spec_strobe, spectrum_io_reset, spectrum_console_reset;
   logic spectrum_power_on, spec_mask_in, spec_int_req;
   logic [2:0] spec_instr;
   logic [1:0] spec_ctl;
   logic [7:0] sense_input_line;
   int bad_count = 0;
   int samples_checked = 0;
   logic [31:0] seed = 32'hcc94_ca80;
   logic [15:0] w, last_in;
   dxp_port dxp_port_i (.core_clk, .rst_n, .main_dev_addr, .outbound_word_lines,
      .pulse_output_line, .main_console_reset, .inbound_word_lines, .sense_input_line,
      .spec_dev_code, .spec_instr, .spec_ctl, .spec_strobe, .spec_word_out,
      .spectrum_io_reset, .spectrum_console_reset, .spectrum_power_on, .spec_mask_in,
      .spec_word_in, .spec_int_req);
   dxp_partner dxp_partner_i (.core_clk, .main_dev_addr, .outbound_word_lines,
      .pulse_output_line, .main_console_reset, .spec_dev_code, .spec_instr, .spec_ctl,
      .spec_strobe, .spec_word_out, .spectrum_io_reset, .spectrum_console_reset,
      .spectrum_power_on, .spec_mask_in);
   always #5 core_clk = ~core_clk;
   function automatic logic [15:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[15:0];
   endfunction
   function automatic logic [15:0] stw(input logic mr, d, c, s1, s2);
      return {s2, s1, c, d, mr, 11'h000};
   endfunction
   task automatic mp(input logic [5:0] p, input logic [5:0] a, input logic [15:0] x);
      dxp_partner_i.main_pulse(p, a, x);
   endtask
   task automatic sp(input logic [2:0] i, input logic [1:0] c, input logic [15:0] x);
      dxp_partner_i.spec_cycle(i, c, 6'h04, x);
   endtask
   task automatic status_is(input logic [15:0] e);
      sp(rd_stat, 2'h0, rnd());
      `CHK("status word", e, spec_word_in);
   endtask
   task automatic give_verdict;
      if (bad_count == 0 && samples_checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      #60000;
      bad_count++;
      give_verdict();
   end
   initial begin
      repeat (16) @(negedge core_clk);
      rst_n = 1'b1;
      repeat (6) @(negedge core_clk);
      `CHK("sense", 8'hc0, sense_input_line);
      `CHK("spec out", 17'h0_0000, {spec_int_req, spec_word_in});
      mp(6'h20, 6'h37, rnd());
      `CHK("sense", 8'h80, sense_input_line);
      for (int i = 0; i < 6; i++) begin
         w = rnd();
         mp(i[0] ? 6'h04 : 6'h02, 6'h37, w);
         `CHK("int", 1'b1, spec_int_req);
         `CHK("sense", 8'h80, sense_input_line);
         sp(i[0] ? rd_cmd : rd_data, 2'h0, rnd());
         `CHK("spec word", w, spec_word_in);
         `CHK("sense", 8'h81, sense_input_line);
         status_is(stw(0, 0, 0, 0, 0));
         last_in = rnd();
         sp(i[0] ? wr_cmd : wr_data, 2'h0, last_in);
         `CHK("inbound", last_in, inbound_word_lines);
         `CHK("sense", i[0] ? 8'h85 : 8'h83, sense_input_line);
         sp(wr_third, 2'h0, ~last_in);
         `CHK("inbound", last_in, inbound_word_lines);
         mp(6'h01, 6'h37, rnd());
         `CHK("sense", 8'h81, sense_input_line);
      end
      dxp_partner_i.reset_pins(3'b100);
      mp(6'h1e, 6'h37, rnd());
      status_is(stw(1, 1, 1, 1, 1));
      status_is(stw(0, 1, 1, 1, 1));
      mp(6'h20, 6'h37, rnd());
      status_is(stw(0, 0, 0, 0, 0));
      // set and clear in one cycle: the clear must win
      mp(6'h22, 6'h37, rnd());
      status_is(stw(0, 0, 0, 0, 0));
      mp(6'h02, 6'h36, rnd());
      `CHK("int", 1'b0, spec_int_req);
      dxp_partner_i.spec_cycle(wr_data, 2'h0, 6'h05, rnd());
      `CHK("inbound", last_in, inbound_word_lines);
      `CHK("sense", 8'h80, sense_input_line);
      sp(no_op, 2'h3, rnd());
      `CHK("sense", 8'h88, sense_input_line);
      sp(no_op, 2'h1, rnd());
      `CHK("sense", 8'h88, sense_input_line);
      mp(6'h20, 6'h37, rnd());
      `CHK("sense", 8'h80, sense_input_line);
      last_in = rnd();
      sp(wr_data, 2'h3, last_in);
      `CHK("sense", 8'h8a, sense_input_line);
      sp(no_op, 2'h2, rnd());
      `CHK("sense", 8'h80, sense_input_line);
      mp(6'h02, 6'h37, rnd());
      dxp_partner_i.set_level(1'b1, 1'b1);
      `CHK("int", 1'b0, spec_int_req);
      dxp_partner_i.set_level(1'b1, 1'b0);
      `CHK("int", 1'b1, spec_int_req);
      sp(wr_data, 2'h0, rnd());
      dxp_partner_i.reset_pins(3'b001);
      `CHK("sense", 8'hc0, sense_input_line);
      `CHK("int", 1'b0, spec_int_req);
      mp(6'h20, 6'h37, rnd());
      dxp_partner_i.reset_pins(3'b010);
      `CHK("sense", 8'hc0, sense_input_line);
      mp(6'h20, 6'h37, rnd());
      dxp_partner_i.set_level(1'b0, 1'b0);
      `CHK("sense", 8'h00, sense_input_line);
      dxp_partner_i.set_level(1'b1, 1'b0);
      `CHK("sense", 8'hc0, sense_input_line);
      give_verdict();
   end
endmodule
